// [src/clock_select_pkg.sv]
// Constants for the redundant clock select and monitor block
package clock_select_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_INT_STATUS = 12'h008;
  localparam logic [11:0] ADDR_INT_MASK = 12'h00c;

  // Control register fields
  localparam int CTRL_W = 7;
  localparam int CTRL_PRIMARY_SELECT = 0;
  localparam int CTRL_TIMEOUT_LONG = 1;
  localparam int CTRL_OE_SINGLE = 2;
  localparam int CTRL_OE_TRIPLE = 3;
  localparam int CTRL_RANGE_LO = 4;
  localparam int CTRL_RANGE_HI = 5;
  localparam int CTRL_AUTO = 6;
  localparam logic [6:0] CTRL_RESET = 7'h7f;

  // Status register fields
  localparam int STAT_LOSS = 0;
  localparam int STAT_REF_PRIMARY = 1;
  localparam int STAT_PLL_ON = 2;
  localparam int STAT_ALIGNED = 3;
  localparam int STAT_RANGE = 4;

  // Interrupt bits
  localparam int INT_W = 4;
  localparam int INT_LOSS = 0;
  localparam int INT_RESTORE = 1;
  localparam int INT_SWITCH = 2;
  localparam int INT_MISALIGN = 3;
  localparam logic [3:0] INT_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // Loss timeout in backup clock periods
  localparam int CNT_W = 6;
  localparam logic [5:0] TIMEOUT_SHORT = 6'h03;
  localparam logic [5:0] TIMEOUT_LONG = 6'h30;
  localparam logic [5:0] CNT_MAX = 6'h3f;

  // Reference input range codes, {hi, lo}
  localparam logic [1:0] RANGE_50_150 = 2'h0;
  localparam logic [1:0] RANGE_19_75 = 2'h1;
  localparam logic [1:0] RANGE_6_19 = 2'h2;
  localparam logic [1:0] RANGE_150_200 = 2'h3;

  typedef enum logic [0:0] {SW_RUN, SW_PARK} switch_e;
endpackage

// [src/clock_select_monitor.sv]
// Redundant clock select, loss monitor and output enable control
// Behaviour
// - Manual mode: select 1 takes primary clock, select 0 the backup clock.
// - Automatic mode: the loss detector, not the select bit, picks the reference.
// - Detector watches primary only; in automatic mode loss flag high selects the backup clock.
// - Timeout select low: loss after about 3 backup periods without primary edges.
// - Timeout select high: loss after about 48 backup periods without edges.
// - Primary edge clears loss flag; automatic mode then reselects primary through the glitch-free handover.
// - Single enable drives output 1; triple drives 2 to 4; both drive all.
// - Both enables low: all outputs high impedance and PLL powered down.
// - Range code {hi,lo}: 00 50-150, 01 19-75, 10 6-19, 11 150-200 MHz.
// - Reference change never produces a shortened pulse or glitch.
// - Feedback rising edges are checked against selected reference rising edges; a stray one flags misalignment.
// - All control inputs read high when left alone.
`timescale 1ns/1ps
module clock_select_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic primary_clock_in,
  input wire logic backup_clock_in,
  input wire logic feedback_clock_in,
  output logic clock_out_first,
  output logic clock_out_first_oe,
  output logic [2:0] clock_out_group,
  output logic clock_out_group_oe,
  output logic pll_power_down,
  output logic [1:0] pll_range,
  output logic reference_is_primary,
  output logic primary_loss_flag,
  output logic irq
);

  // Pin synchronisers: primary, backup, feedback
  logic [2:0] pin_in;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;

  assign pin_in = {feedback_clock_in, backup_clock_in, primary_clock_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
        end
      end
    end
  endgenerate

  wire primary_s = sync2_r[0];
  wire backup_s = sync2_r[1];
  wire primary_edge = sync2_r[0] ^ sync3_r[0];
  wire backup_rise = sync2_r[1] & ~sync3_r[1];
  wire fb_rise = sync2_r[2] & ~sync3_r[2];

  // Registers
  logic [6:0] ctrl_r;
  logic [3:0] int_status_r;
  logic [3:0] int_mask_r;
  logic [31:0] prdata_r;

  wire sel_primary_bit = ctrl_r[clock_select_pkg::CTRL_PRIMARY_SELECT];
  wire timeout_long = ctrl_r[clock_select_pkg::CTRL_TIMEOUT_LONG];
  wire output_enable_single = ctrl_r[clock_select_pkg::CTRL_OE_SINGLE];
  wire output_enable_triple = ctrl_r[clock_select_pkg::CTRL_OE_TRIPLE];
  wire range_select_lo = ctrl_r[clock_select_pkg::CTRL_RANGE_LO];
  wire range_select_hi = ctrl_r[clock_select_pkg::CTRL_RANGE_HI];
  wire auto_mode = ctrl_r[clock_select_pkg::CTRL_AUTO];

  // Bus decode
  wire hit_ctrl = paddr == clock_select_pkg::ADDR_CTRL;
  wire hit_status = paddr == clock_select_pkg::ADDR_STATUS;
  wire hit_int = paddr == clock_select_pkg::ADDR_INT_STATUS;
  wire hit_mask = paddr == clock_select_pkg::ADDR_INT_MASK;
  wire hit_any = hit_ctrl | hit_status | hit_int | hit_mask;
  wire setup_rd = psel & ~penable & ~pwrite;
  wire wr_acc = psel & penable & pwrite & hit_any & pstrb[0];
  wire wr_ctrl = wr_acc & hit_ctrl;
  wire wr_int = wr_acc & hit_int;
  wire wr_mask = wr_acc & hit_mask;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata = prdata_r;

  // Loss detector
  logic [5:0] loss_cnt_r;
  logic [5:0] loss_cnt_nxt;
  logic loss_r;
  logic loss_nxt;
  wire [5:0] timeout_sel = timeout_long ? clock_select_pkg::TIMEOUT_LONG :
                                          clock_select_pkg::TIMEOUT_SHORT;

  // Sampling limits the detector to clocks below half of pclk
  always_comb begin
    loss_cnt_nxt = loss_cnt_r;
    loss_nxt = loss_r;
    if (primary_edge) begin
      loss_cnt_nxt = '0;
      loss_nxt = 1'b0;
    end else begin
      if (backup_rise && loss_cnt_r != clock_select_pkg::CNT_MAX) begin
        loss_cnt_nxt = loss_cnt_r + 6'h01;
      end
      if (loss_cnt_nxt >= timeout_sel) begin
        loss_nxt = 1'b1;
      end
    end
  end

  // Reference choice and glitch-free handover
  wire pll_on = output_enable_single | output_enable_triple;
  wire want_primary = auto_mode ? ~loss_r : sel_primary_bit;
  clock_select_pkg::switch_e sw_state_r;
  clock_select_pkg::switch_e sw_state_nxt;
  logic cur_primary_r;
  logic cur_primary_nxt;
  logic ref_out_r;
  logic ref_out_nxt;
  wire src_now = cur_primary_r ? primary_s : backup_s;
  wire src_new = want_primary ? primary_s : backup_s;
  // Previous level of the running source, used to find a fresh rise
  wire src_prev = cur_primary_r ? sync3_r[0] : sync3_r[1];
  // A dead primary may be parked high, so in automatic mode loss lets it go at once
  wire old_done = ~ref_out_r | (auto_mode & loss_r & cur_primary_r);

  always_comb begin
    sw_state_nxt = sw_state_r;
    cur_primary_nxt = cur_primary_r;
    ref_out_nxt = ref_out_r;
    case (sw_state_r)
      clock_select_pkg::SW_RUN: begin
        // Power-up waits for a fresh source rise, so the first pulse is whole
        ref_out_nxt = src_now & pll_on & (ref_out_r | ~src_prev);
        if (want_primary != cur_primary_r && old_done) begin
          sw_state_nxt = clock_select_pkg::SW_PARK;
          ref_out_nxt = 1'b0;
        end
      end
      clock_select_pkg::SW_PARK: begin
        ref_out_nxt = 1'b0;
        if (!src_new) begin
          cur_primary_nxt = want_primary;
          sw_state_nxt = clock_select_pkg::SW_RUN;
        end
      end
      default: begin
        sw_state_nxt = clock_select_pkg::SW_RUN;
        ref_out_nxt = 1'b0;
      end
    endcase
  end

  // Feedback alignment
  // Feedback synchroniser lags two cycles, so the window is delayed to match
  logic ref_out_d_r;
  logic ref_rise_d_r;
  logic ref_rise_dd_r;
  logic aligned_r;
  wire ref_rise = ref_out_r & ~ref_out_d_r;
  wire fb_window = ref_rise_d_r | ref_rise_dd_r;
  wire fb_ok = fb_rise & fb_window;
  wire fb_bad = fb_rise & ~fb_window & pll_on;

  // Events
  logic [3:0] events;
  assign events[clock_select_pkg::INT_LOSS] = loss_nxt & ~loss_r;
  assign events[clock_select_pkg::INT_RESTORE] = ~loss_nxt & loss_r;
  assign events[clock_select_pkg::INT_SWITCH] = cur_primary_nxt ^ cur_primary_r;
  assign events[clock_select_pkg::INT_MISALIGN] = fb_bad;

  // Set wins over a write-one clear in the same cycle
  wire [3:0] int_clear = wr_int ? pwdata[3:0] : 4'h0;
  wire [3:0] int_status_nxt = (int_status_r & ~int_clear) | events;

  wire [31:0] status_word = {26'h0, pll_range,
                             aligned_r, pll_on, cur_primary_r, loss_r};
  wire [31:0] rd_word = hit_ctrl ? {25'h0, ctrl_r} :
                        hit_status ? status_word :
                        hit_int ? {28'h0, int_status_r} :
                        hit_mask ? {28'h0, int_mask_r} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= clock_select_pkg::CTRL_RESET;
      int_status_r <= clock_select_pkg::INT_RESET;
      int_mask_r <= clock_select_pkg::MASK_RESET;
      prdata_r <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata[6:0];
      end
      if (wr_mask) begin
        int_mask_r <= pwdata[3:0];
      end
      int_status_r <= int_status_nxt;
      if (setup_rd) begin
        prdata_r <= rd_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loss_cnt_r <= '0;
      loss_r <= 1'b0;
      sw_state_r <= clock_select_pkg::SW_RUN;
      cur_primary_r <= 1'b1;
      ref_out_r <= 1'b0;
      ref_out_d_r <= 1'b0;
      ref_rise_d_r <= 1'b0;
      ref_rise_dd_r <= 1'b0;
      aligned_r <= 1'b0;
    end else begin
      loss_cnt_r <= loss_cnt_nxt;
      loss_r <= loss_nxt;
      sw_state_r <= sw_state_nxt;
      cur_primary_r <= cur_primary_nxt;
      ref_out_r <= ref_out_nxt;
      ref_out_d_r <= ref_out_r;
      ref_rise_d_r <= ref_rise;
      ref_rise_dd_r <= ref_rise_d_r;
      if (fb_ok) begin
        aligned_r <= 1'b1;
      end else if (fb_bad || !pll_on) begin
        aligned_r <= 1'b0;
      end
    end
  end

  // Pin drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_out_first <= 1'b0;
      clock_out_group <= 3'h0;
      clock_out_first_oe <= 1'b1;
      clock_out_group_oe <= 1'b1;
      pll_power_down <= 1'b0;
      pll_range <= clock_select_pkg::RANGE_150_200;
      reference_is_primary <= 1'b1;
      primary_loss_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      clock_out_first <= ref_out_nxt;
      clock_out_group <= {3{ref_out_nxt}};
      clock_out_first_oe <= output_enable_single;
      clock_out_group_oe <= output_enable_triple;
      pll_power_down <= ~pll_on;
      pll_range <= {range_select_hi, range_select_lo};
      reference_is_primary <= cur_primary_nxt;
      primary_loss_flag <= loss_nxt;
      irq <= |(int_status_nxt & int_mask_r);
    end
  end

endmodule

// [sim/clock_sources.sv]
// Clock sources and feedback loop around the clock selector
`timescale 1ns/1ps
module clock_sources (
  input wire logic primary_run,
  input wire logic clock_out_first,
  input wire logic clock_out_first_oe,
  input wire logic [2:0] clock_out_group,
  input wire logic clock_out_group_oe,
  output logic primary_clock_in,
  output logic backup_clock_in,
  output logic feedback_clock_in
);
  // Stopped primary holds its level, like a dead oscillator
  initial begin
    primary_clock_in = 1'h0;
    forever #21 primary_clock_in = primary_run ? ~primary_clock_in : primary_clock_in;
  end
  // Periods not multiples of pclk, so sampling phase drifts
  initial begin
    backup_clock_in = 1'h0;
    forever #17 backup_clock_in = ~backup_clock_in;
  end
  // Tap an enabled output; with both outputs disabled the feedback stays low
  assign feedback_clock_in = clock_out_group_oe ? clock_out_group[0] :
    clock_out_first & clock_out_first_oe;
endmodule

// [sim/clock_select_monitor_properties.sv]
// Port assertions for the clock select monitor
`timescale 1ns/1ps
module clock_select_monitor_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic primary_clock_in,
  input wire logic clock_out_first,
  input wire logic clock_out_first_oe,
  input wire logic clock_out_group_oe,
  input wire logic pll_power_down,
  input wire logic reference_is_primary,
  input wire logic primary_loss_flag
);
  logic auto_r;
  logic sel_r;
  logic prim_r;
  logic [5:0] quiet_r;
  wire ctrl_wr = psel && penable && pwrite && pready && pstrb[0]
    && paddr == clock_select_pkg::ADDR_CTRL;
  // Saturates so a long stop cannot wrap back to small counts
  wire [5:0] quiet_nxt = (prim_r != primary_clock_in) ? 6'h00 :
    quiet_r + {5'h00, quiet_r != 6'h3f};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_r <= 1'h1;
      sel_r <= 1'h1;
      prim_r <= 1'h0;
      quiet_r <= 6'h00;
    end else begin
      auto_r <= ctrl_wr ? pwdata[clock_select_pkg::CTRL_AUTO] : auto_r;
      sel_r <= ctrl_wr ? pwdata[clock_select_pkg::CTRL_PRIMARY_SELECT] : sel_r;
      prim_r <= primary_clock_in;
      quiet_r <= quiet_nxt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence high_run_s;
    (clock_out_first || pll_power_down) [*3];
  endsequence
  pll_down_a: assert property (pll_power_down == (!clock_out_first_oe && !clock_out_group_oe))
    else $error("power down disagrees with enables");
  down_quiet_a: assert property (pll_power_down |-> !clock_out_first)
    else $error("output toggles while powered down");
  loss_quiet_a: assert property ($rose(primary_loss_flag) |-> quiet_r >= 6'h08)
    else $error("loss flag raised while primary active");
  loss_clear_a: assert property ($changed(primary_clock_in) |-> ##[1:5] !primary_loss_flag)
    else $error("loss flag not cleared by primary edge");
  ref_backup_a: assert property (auto_r && primary_loss_flag |-> ##[0:12] !reference_is_primary)
    else $error("backup not selected after loss");
  ref_return_a: assert property (auto_r && $fell(primary_loss_flag) |-> ##[0:14] reference_is_primary)
    else $error("primary not reselected");
  manual_sel_a: assert property (!auto_r && !pll_power_down && reference_is_primary != sel_r
    |-> ##[1:20] reference_is_primary == sel_r)
    else $error("manual select not followed");
  pulse_whole_a: assert property ($rose(clock_out_first) |-> high_run_s)
    else $error("shortened output pulse");
endmodule
bind clock_select_monitor clock_select_monitor_properties chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pready, .primary_clock_in, .clock_out_first,
  .clock_out_first_oe, .clock_out_group_oe, .pll_power_down, .reference_is_primary,
  .primary_loss_flag);

// [sim/redundant_clock_select_monitor_tb.sv]
// Self-checking bench for the redundant clock select monitor
`timescale 1ns/1ps
module redundant_clock_select_monitor_tb;
  localparam logic [11:0] CTRL = clock_select_pkg::ADDR_CTRL;
  localparam logic [11:0] INTS = clock_select_pkg::ADDR_INT_STATUS;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, primary_run, irq;
  logic primary_clock_in, backup_clock_in, feedback_clock_in, clock_out_first;
  logic clock_out_first_oe, clock_out_group_oe, pll_power_down, reference_is_primary;
  logic primary_loss_flag;
  logic [2:0] clock_out_group;
  logic [1:0] pll_range;
  logic [3:0] pstrb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int bad_count, checked, cyc;
  clock_select_monitor DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .primary_clock_in, .backup_clock_in, .feedback_clock_in,
    .clock_out_first, .clock_out_first_oe, .clock_out_group, .clock_out_group_oe,
    .pll_power_down, .pll_range, .reference_is_primary, .primary_loss_flag, .irq);
  clock_sources src (.primary_run, .clock_out_first, .clock_out_first_oe, .clock_out_group,
    .clock_out_group_oe, .primary_clock_in, .backup_clock_in, .feedback_clock_in);
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic finish_test();
    $display("Checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Bounded wait, a slow design shows as a mismatch
  task automatic lvl(input string n, ref logic s, input logic v);
    for (int k = 0; k < 60 && s !== v; k++) @(posedge pclk);
    chk(n, v, s);
  endtask
  task automatic loss_time(input int lo, input int hi);
    int n;
    n = 0;
    // Stop right after an edge, so the count starts at the last transition
    @(primary_clock_in);
    primary_run = 1'h0;
    while (primary_loss_flag !== 1'h1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    chk("loss delay", 1, n >= lo && n <= hi);
  endtask
  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    primary_run = 1'h1;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, CTRL, 0);
    chk("ctrl reset", 32'h7f, q);
    apb(1'h0, 12'h010, 0);
    chk("unmapped", 32'h1, {q[30:0], err});
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, CTRL, 32'h4d | (i << 4));
      apb(1'h0, clock_select_pkg::ADDR_STATUS, 0);
      chk("range", {i[1:0], i[1:0]}, {pll_range, q[5:4]});
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, CTRL, 32'h71 | (i << 2));
      repeat (2) @(posedge pclk);
      chk("enables", {i[1:0], i == 0}, {clock_out_group_oe, clock_out_first_oe, pll_power_down});
    end
    apb(1'h1, CTRL, 32'h3c);
    lvl("manual backup", reference_is_primary, 1'h0);
    apb(1'h1, CTRL, 32'h3d);
    lvl("manual primary", reference_is_primary, 1'h1);
    // Range 11 kept for both inputs, though at about 24 and 29 MHz both lie in range 01
    apb(1'h1, CTRL, 32'h7d);
    apb(1'h1, INTS, 32'hf);
    loss_time(13, 36);
    lvl("auto backup", reference_is_primary, 1'h0);
    apb(1'h0, INTS, 0);
    chk("events", 32'h5, q & 32'h7);
    chk("irq masked", 0, irq);
    apb(1'h1, clock_select_pkg::ADDR_INT_MASK, 32'h1);
    lvl("irq raised", irq, 1'h1);
    apb(1'h1, INTS, 32'h1);
    lvl("irq cleared", irq, 1'h0);
    primary_run <= 1'h1;
    lvl("loss cleared", primary_loss_flag, 1'h0);
    lvl("auto primary", reference_is_primary, 1'h1);
    repeat (30) @(posedge pclk);
    apb(1'h0, clock_select_pkg::ADDR_STATUS, 0);
    chk("aligned", 2'h3, q[3:2]);
    chk("group clock", {3{clock_out_first}}, clock_out_group);
    apb(1'h1, CTRL, 32'h7f);
    loss_time(217, 445);
    primary_run <= 1'h1;
    lvl("long restore", primary_loss_flag, 1'h0);
    finish_test();
  end
endmodule
